// *** hw/eelq_cfg.svh ***
// Purpose: constants of the event log queue
// Assumes: 10 MHz clock, 16-bit register words
// Notes: codes are 8 bits, upper register bits read zero
`ifndef EELQ_CFG_SVH
`define EELQ_CFG_SVH
// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define EELQ_ADDR_POP 16'h06ae
`define EELQ_ADDR_HIST_NEWEST 16'h06b4
`define EELQ_ADDR_HIST_OLDEST 16'h06bb
`define EELQ_DEPTH 8
`define EELQ_NO_CODE 8'h00
`define EELQ_CLEAR_VALUE 16'h0000
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define EELQ_CLK_NS 100
`define EELQ_CLK_KHZ 10000
`define EELQ_UNLOCK_HOLD_MS 5000
`define EELQ_CHAR_NS 1041667
`define EELQ_GAP_CHAR_X2 7
`define EELQ_SHORT_BYTES 3'h4
// ------------------------------------------------------------
// event codes: base value of each class, span of ranged classes
// ------------------------------------------------------------
`define EELQ_C_NVDATA 8'h3b
`define EELQ_C_MOVF 8'h3e
`define EELQ_N_MOVF 5'h05
`define EELQ_C_CAL 8'h43
`define EELQ_C_CFG 8'h44
`define EELQ_C_FREQ 8'h45
`define EELQ_C_NVM_A 8'h46
`define EELQ_C_NVM_B 8'h4a
`define EELQ_C_MERR 8'h4b
`define EELQ_N_MERR 5'h03
`define EELQ_C_HIV 8'h4e
`define EELQ_N_HIV 5'h06
`define EELQ_C_ACC 8'h54
`define EELQ_N_ACC 5'h17
`define EELQ_C_PULSE 8'h6b
`define EELQ_C_RO 8'hc5
`define EELQ_C_AUXDIR 8'hc6
`define EELQ_C_AUXLVL 8'hc7
`define EELQ_C_LOCKED 8'hc8
`define EELQ_C_VERIFY 8'hca
`define EELQ_C_DUAL 8'hcb
`define EELQ_C_BADUNL 8'hcd
`define EELQ_C_BADADR 8'hce
`define EELQ_C_BADDAT 8'hcf
`define EELQ_C_BADCFG 8'hd0
`define EELQ_C_HOLD 8'hd1
`define EELQ_C_BADLEN 8'hd3
`define EELQ_N_BADLEN 5'h02
`define EELQ_C_BADFN 8'hd5
`define EELQ_C_TCPHDR 8'hf1
`define EELQ_C_EXTRA_A 8'hf2
`define EELQ_C_TCPTMO 8'hf4
`define EELQ_C_TCPLEN 8'hf5
`define EELQ_C_EXTRA_B 8'hf6
`define EELQ_C_PARITY 8'hf7
`define EELQ_C_CONTEND 8'hf8
`define EELQ_C_DUPADR 8'hf9
`define EELQ_C_OVERRUN 8'hfa
`define EELQ_C_RXERR 8'hfb
`define EELQ_C_SHORT 8'hfc
`define EELQ_N_SHORT 5'h02
`define EELQ_C_FSTART 8'hfe
`define EELQ_C_CRC 8'hff
`endif

// *** hw/eelq_pkg.sv ***
// Purpose: types of the event log queue
// Assumes: constants come from eelq_cfg.svh
// Notes: none
`default_nettype none
package eelq_pkg;
    typedef enum logic [5:0] {
        EV_NVDATA = 6'h00, EV_MOVF = 6'h01, EV_CAL = 6'h02,
        EV_CFG = 6'h03, EV_FREQ = 6'h04, EV_NVM = 6'h05,
        EV_MERR = 6'h06, EV_HIV = 6'h07, EV_ACC = 6'h08,
        EV_PULSE = 6'h09, EV_RO = 6'h0a, EV_AUXDIR = 6'h0b,
        EV_AUXLVL = 6'h0c, EV_LOCKED = 6'h0d, EV_VERIFY = 6'h0e,
        EV_DUAL = 6'h0f, EV_BADUNL = 6'h10, EV_BADADR = 6'h11,
        EV_BADDAT = 6'h12, EV_BADCFG = 6'h13, EV_BADLEN = 6'h14,
        EV_BADFN = 6'h15, EV_TCPHDR = 6'h16, EV_TCPTMO = 6'h17,
        EV_TCPLEN = 6'h18, EV_EXTRA = 6'h19, EV_CONTEND = 6'h1a,
        EV_DUPADR = 6'h1b, EV_PARITY = 6'h1c, EV_OVERRUN = 6'h1d,
        EV_RXERR = 6'h1e, EV_SHORT = 6'h1f, EV_FSTART = 6'h20,
        EV_CRC = 6'h21
    } eelq_class_e;

    typedef enum logic [0:0] {
        ST_RESTORE = 1'b0,
        ST_RUN = 1'b1
    } eelq_fsm_e;

    typedef struct packed {
        eelq_fsm_e fsm;
        logic [7:0][7:0] popMem;
        logic [2:0] popHead;
        logic [3:0] popCnt;
        logic [7:0][7:0] hist;
        logic [15:0] rdData;
        logic rdValid;
        logic nvWr;
        logic pendRo;
        logic pendHold;
        logic pendShort;
        logic [31:0] gapCnt;
        logic [2:0] byteCnt;
        logic [31:0] lockCnt;
        logic unlockRej;
        logic halted;
    } eelq_state_s;
endpackage
`default_nettype wire

// *** hw/eelq_log_queue.sv ***
// Purpose: event log with pop register and history registers
// Assumes: register port is the protocol engine's word access
// Notes: pop queue image is saved/restored via nv ports
`include "eelq_cfg.svh"
`default_nettype none
// Overview of operation
// RULE1: keep eight newest codes in both views
// RULE2: pop read returns oldest code, removes it
// RULE3: empty pop read returns zero, meaning none
// RULE4: pop queue image survives power loss
// RULE5: each code popped at most once
// RULE6: history one newest, eight oldest, by age
// RULE7: history reads never change history
// RULE8: zero write clears history; history volatile
// RULE9: log 59, 67 halting, 68 data losses
// RULE10: log 70/74 memory, 75-77 measurement
// RULE11: log 62-66 overflow, 69 frequency
// RULE12: log 78-83 high line voltage
// RULE13: log 84-106 on accumulator wrap
// RULE14: log 107 on pulse tally wrap
// RULE15: log 197, 198, 199 write faults
// RULE16: log 200, 202, 203, 205 unlock faults
// RULE17: refuse unlock within 5 s, log 209
// RULE18: log 206-208, 211/212, 213 request faults
// RULE19: log 241, 244, 245 in tcp mode only
// RULE20: log 242/246, 248, 249 bus faults
// RULE21: log 247, 250, 251, 254, 255 receive faults
// RULE22: short frame before 3.5 char gap: 252
// RULE23: full log drops oldest entry
module eelq_log_queue
    import eelq_pkg::*;
#(
    parameter int HOLD_CYC = `EELQ_UNLOCK_HOLD_MS * `EELQ_CLK_KHZ,
    parameter int GAP_CYC = (`EELQ_CHAR_NS * `EELQ_GAP_CHAR_X2 / 2
        + `EELQ_CLK_NS - 1) / `EELQ_CLK_NS
) (
    input wire logic clk, // 10 MHz clock
    input wire logic rst_b, // async reset, power cycle
    input wire logic regRd, // register read strobe
    input wire logic regWr, // register write strobe
    input wire logic [15:0] regAddr, // register address
    input wire logic [15:0] regWdata, // write data
    output logic [15:0] regRdata, // read data
    output logic regRvalid, // read data valid pulse
    input wire logic evStrobe, // event pulse
    input wire eelq_class_e evClass, // event class
    input wire logic [4:0] evSub, // index within class
    input wire logic tcpFramedSerialMode, // tcp framing on
    input wire logic rxByte, // byte received pulse
    input wire logic unlockTry, // unlock attempt pulse
    input wire logic unlockFail, // failed unlock pulse
    output logic unlockRejected, // attempt refused pulse
    output logic measureHalted, // calibration lost
    input wire logic [70:0] nvRestoreImage, // saved queue
    output logic [70:0] nvImage, // queue image to save
    output logic nvWrStrobe // image save pulse, on each append and on every pop read, empty ones too
);
    // ------------------------------------------------------------
    // code encoding
    // ------------------------------------------------------------
    function automatic logic [7:0] ranged(
        input logic [7:0] base,
        input logic [4:0] span,
        input logic [4:0] sub
    );
        logic [4:0] s;
        s = (sub >= span) ? span - 5'h01 : sub;
        ranged = base + {3'h0, s};
    endfunction

    function automatic logic [7:0] codeOf(
        input eelq_class_e c,
        input logic [4:0] sub,
        input logic tcp
    );
        codeOf = `EELQ_NO_CODE;
        case (c)
            EV_NVDATA: codeOf = `EELQ_C_NVDATA; // RULE9
            EV_CAL: codeOf = `EELQ_C_CAL; // RULE9
            EV_CFG: codeOf = `EELQ_C_CFG; // RULE9
            EV_MOVF: codeOf = ranged(`EELQ_C_MOVF, `EELQ_N_MOVF,
                sub); // RULE11
            EV_FREQ: codeOf = `EELQ_C_FREQ; // RULE11
            EV_NVM: codeOf = (sub == 5'h00) ? `EELQ_C_NVM_A
                : `EELQ_C_NVM_B; // RULE10
            EV_MERR: codeOf = ranged(`EELQ_C_MERR, `EELQ_N_MERR,
                sub); // RULE10
            EV_HIV: codeOf = ranged(`EELQ_C_HIV, `EELQ_N_HIV,
                sub); // RULE12
            EV_ACC: codeOf = ranged(`EELQ_C_ACC, `EELQ_N_ACC,
                sub); // RULE13
            EV_PULSE: codeOf = `EELQ_C_PULSE; // RULE14
            EV_RO: codeOf = `EELQ_C_RO; // RULE15
            EV_AUXDIR: codeOf = `EELQ_C_AUXDIR; // RULE15
            EV_AUXLVL: codeOf = `EELQ_C_AUXLVL; // RULE15
            EV_LOCKED: codeOf = `EELQ_C_LOCKED; // RULE16
            EV_VERIFY: codeOf = `EELQ_C_VERIFY; // RULE16
            EV_DUAL: codeOf = `EELQ_C_DUAL; // RULE16
            EV_BADUNL: codeOf = `EELQ_C_BADUNL; // RULE16
            EV_BADADR: codeOf = `EELQ_C_BADADR; // RULE18
            EV_BADDAT: codeOf = `EELQ_C_BADDAT; // RULE18
            EV_BADCFG: codeOf = `EELQ_C_BADCFG; // RULE18
            EV_BADLEN: codeOf = ranged(`EELQ_C_BADLEN,
                `EELQ_N_BADLEN, sub); // RULE18
            EV_BADFN: codeOf = `EELQ_C_BADFN; // RULE18
            EV_TCPHDR: codeOf = tcp ? `EELQ_C_TCPHDR
                : `EELQ_NO_CODE; // RULE19
            EV_TCPTMO: codeOf = tcp ? `EELQ_C_TCPTMO
                : `EELQ_NO_CODE; // RULE19
            EV_TCPLEN: codeOf = tcp ? `EELQ_C_TCPLEN
                : `EELQ_NO_CODE; // RULE19
            EV_EXTRA: codeOf = (sub == 5'h00) ? `EELQ_C_EXTRA_A
                : `EELQ_C_EXTRA_B; // RULE20
            EV_CONTEND: codeOf = `EELQ_C_CONTEND; // RULE20
            EV_DUPADR: codeOf = `EELQ_C_DUPADR; // RULE20
            EV_PARITY: codeOf = `EELQ_C_PARITY; // RULE21
            EV_OVERRUN: codeOf = `EELQ_C_OVERRUN; // RULE21
            EV_RXERR: codeOf = `EELQ_C_RXERR; // RULE21
            EV_SHORT: codeOf = ranged(`EELQ_C_SHORT,
                `EELQ_N_SHORT, sub); // RULE22
            EV_FSTART: codeOf = `EELQ_C_FSTART; // RULE21
            EV_CRC: codeOf = `EELQ_C_CRC; // RULE21
            default: codeOf = `EELQ_NO_CODE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    eelq_state_s q;
    eelq_state_s next_q;

    always_comb begin
        logic [7:0] code;
        logic [7:0] extCode;
        logic [2:0] idx;
        logic [2:0] slot;
        logic setRo;
        logic setHold;
        logic setShort;
        logic useRo;
        logic useHold;
        logic useShort;
        logic rdHit;
        code = `EELQ_NO_CODE;
        extCode = codeOf(evClass, evSub, tcpFramedSerialMode);
        idx = 3'(regAddr - `EELQ_ADDR_HIST_NEWEST);
        slot = 3'h0;
        setRo = 1'b0;
        setHold = 1'b0;
        setShort = 1'b0;
        useRo = 1'b0;
        useHold = 1'b0;
        useShort = 1'b0;
        rdHit = 1'b0;
        next_q = q;
        next_q.rdValid = 1'b0;
        next_q.nvWr = 1'b0;
        next_q.unlockRej = 1'b0;

        if (q.fsm == ST_RESTORE) begin
            // reload saved pop queue; a corrupt count empties it
            next_q.popMem = nvRestoreImage[70:7]; // RULE4
            next_q.popHead = nvRestoreImage[6:4];
            next_q.popCnt = (nvRestoreImage[3:0] > 4'h8) ? 4'h0
                : nvRestoreImage[3:0];
            next_q.fsm = ST_RUN;
        end else begin
            // ----------------------------------------------------
            // register reads and writes
            // ----------------------------------------------------
            if (regRd) begin
                next_q.rdValid = 1'b1;
                next_q.rdData = 16'h0000;
                if (regAddr == `EELQ_ADDR_POP) begin
                    rdHit = 1'b1;
                    if (q.popCnt != 4'h0) begin
                        next_q.rdData = {8'h00,
                            q.popMem[q.popHead]}; // RULE2
                        next_q.popHead = q.popHead + 3'h1; // RULE5
                        next_q.popCnt = q.popCnt - 4'h1;
                        next_q.nvWr = 1'b1;
                    end else begin
                        next_q.rdData = {8'h00, `EELQ_NO_CODE}; // RULE3
                    end
                end else if (regAddr >= `EELQ_ADDR_HIST_NEWEST &&
                    regAddr <= `EELQ_ADDR_HIST_OLDEST) begin
                    next_q.rdData = {8'h00, q.hist[idx]}; // RULE7
                end
            end
            if (regWr) begin
                if (regAddr == `EELQ_ADDR_POP) begin
                    setRo = 1'b1; // RULE15
                end else if (regAddr >= `EELQ_ADDR_HIST_NEWEST &&
                    regAddr <= `EELQ_ADDR_HIST_OLDEST &&
                    regWdata == `EELQ_CLEAR_VALUE) begin
                    next_q.hist = '0; // RULE8
                end
            end

            // ----------------------------------------------------
            // unlock hold-off
            // ----------------------------------------------------
            if (q.lockCnt != 32'h0) begin
                next_q.lockCnt = q.lockCnt - 32'h1;
            end
            if (unlockTry && q.lockCnt != 32'h0) begin
                next_q.unlockRej = 1'b1; // RULE17
                setHold = 1'b1; // RULE17
            end
            if (unlockFail) begin
                next_q.lockCnt = 32'(HOLD_CYC); // RULE17
            end

            // ----------------------------------------------------
            // short frame watch
            // ----------------------------------------------------
            if (rxByte) begin
                next_q.gapCnt = 32'h0;
                if (q.byteCnt < `EELQ_SHORT_BYTES) begin
                    next_q.byteCnt = q.byteCnt + 3'h1;
                end
            end else if (q.byteCnt != 3'h0) begin
                next_q.gapCnt = q.gapCnt + 32'h1;
                if (q.gapCnt == GAP_CYC - 1) begin
                    setShort = (q.byteCnt < `EELQ_SHORT_BYTES); // RULE22
                    next_q.byteCnt = 3'h0;
                    next_q.gapCnt = 32'h0;
                end
            end

            // ----------------------------------------------------
            // pick one code per cycle; internal causes wait
            // ----------------------------------------------------
            if (evStrobe && extCode != `EELQ_NO_CODE) begin
                code = extCode;
                if (evClass == EV_CAL) begin
                    next_q.halted = 1'b1; // RULE9
                end
            end else if (q.pendRo) begin
                code = `EELQ_C_RO;
                useRo = 1'b1;
            end else if (q.pendHold) begin
                code = `EELQ_C_HOLD;
                useHold = 1'b1;
            end else if (q.pendShort) begin
                code = `EELQ_C_SHORT;
                useShort = 1'b1;
            end
            // a cause raised while its flag drains is kept
            next_q.pendRo = (q.pendRo & ~useRo) | setRo;
            next_q.pendHold = (q.pendHold & ~useHold) | setHold;
            next_q.pendShort = (q.pendShort & ~useShort) | setShort;

            // ----------------------------------------------------
            // append to both views
            // ----------------------------------------------------
            if (code != `EELQ_NO_CODE) begin
                next_q.hist = {next_q.hist[6:0], code}; // RULE6
                if (next_q.popCnt == 4'(`EELQ_DEPTH)) begin
                    next_q.popMem[next_q.popHead] = code; // RULE23
                    next_q.popHead = next_q.popHead + 3'h1; // RULE23
                end else begin
                    slot = next_q.popHead + next_q.popCnt[2:0];
                    next_q.popMem[slot] = code; // RULE1
                    next_q.popCnt = next_q.popCnt + 4'h1;
                end
                next_q.nvWr = 1'b1; // RULE4
            end
        end
        if (rdHit) begin
            next_q.nvWr = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from state flops
    // ------------------------------------------------------------
    assign regRdata = q.rdData;
    assign regRvalid = q.rdValid;
    assign unlockRejected = q.unlockRej;
    assign measureHalted = q.halted;
    assign nvImage = {q.popMem, q.popHead, q.popCnt};
    assign nvWrStrobe = q.nvWr;
endmodule
`default_nettype wire

// *** verification/eelq_log_queue_properties.sv ***
// Purpose: port checker of the event log queue
// Assumes: one clock, async active low reset
// Notes: bound into every eelq_log_queue instance
`include "eelq_cfg.svh"
`default_nettype none
module eelq_log_queue_properties
    import eelq_pkg::*;
#(
    parameter int HOLD_CYC = 50,
    parameter int GAP_CYC = 20
) (
    input wire logic clk, // clock
    input wire logic rst_b, // async reset
    input wire logic regRd, // read strobe
    input wire logic [15:0] regAddr, // address
    input wire logic [15:0] regRdata, // read data
    input wire logic regRvalid, // read valid
    input wire logic evStrobe, // event pulse
    input wire eelq_class_e evClass, // event class
    input wire logic unlockTry, // unlock attempt
    input wire logic unlockFail, // failed unlock
    input wire logic unlockRejected, // refused attempt
    input wire logic measureHalted, // halted
    input wire logic [70:0] nvImage, // queue image
    input wire logic nvWrStrobe // image save pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic mapped;
    logic [31:0] sinceFail;
    assign mapped = regAddr == `EELQ_ADDR_POP
        || (regAddr >= `EELQ_ADDR_HIST_NEWEST
        && regAddr <= `EELQ_ADDR_HIST_OLDEST);
    // saturates so a long quiet spell never wraps back
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sinceFail <= '1;
        end else if (unlockFail) begin
            sinceFail <= '0;
        end else if (sinceFail != '1) begin
            sinceFail <= sinceFail + 32'h1;
        end
    end
    read_answer_a: assert property (regRd |=> regRvalid)
        else $error("read without answer");
    valid_cause_a: assert property (!regRd |=> !regRvalid)
        else $error("answer without read");
    code_width_a: assert property (
        regRvalid |-> regRdata[15:8] == 8'h00)
        else $error("upper code byte not zero");
    unmapped_zero_a: assert property (
        regRd && !mapped |=> regRdata == 16'h0000)
        else $error("unmapped read not zero");
    pop_commit_a: assert property (
        regRd && regAddr == `EELQ_ADDR_POP |=> nvWrStrobe)
        else $error("pop read not saved");
    event_commit_a: assert property (
        evStrobe && evClass == EV_CRC |=> nvWrStrobe)
        else $error("event not saved");
    halt_sticky_a: assert property (
        (evStrobe && evClass == EV_CAL) || measureHalted |=> measureHalted)
        else $error("halt not held");
    hold_reject_a: assert property (
        unlockFail ##1 unlockTry |=> unlockRejected)
        else $error("attempt in hold-off accepted");
    reject_cause_a: assert property (!unlockTry |=> !unlockRejected)
        else $error("refusal without attempt");
    hold_expiry_a: assert property (
        unlockTry && sinceFail > HOLD_CYC |=> !unlockRejected)
        else $error("refusal after hold-off");
    depth_bound_a: assert property (nvImage[3:0] <= 4'h8)
        else $error("pop count above eight");
endmodule
bind eelq_log_queue eelq_log_queue_properties #(
    .HOLD_CYC(HOLD_CYC), .GAP_CYC(GAP_CYC)
) props (
    .clk(clk), .rst_b(rst_b), .regRd(regRd), .regAddr(regAddr),
    .regRdata(regRdata), .regRvalid(regRvalid), .evStrobe(evStrobe),
    .evClass(evClass), .unlockTry(unlockTry), .unlockFail(unlockFail),
    .unlockRejected(unlockRejected), .measureHalted(measureHalted),
    .nvImage(nvImage), .nvWrStrobe(nvWrStrobe)
);
`default_nettype wire

// *** verification/eelq_master_model.sv ***
// Purpose: register master and pop image store
// Assumes: answer registered on the taking edge
// Notes: store never sees reset, like real flash
`default_nettype none
module eelq_master_model (
    input wire logic clk, // clock
    output logic regRd, // read strobe
    output logic regWr, // write strobe
    output logic [15:0] regAddr, // address
    output logic [15:0] regWdata, // write data
    input wire logic [15:0] regRdata, // read data
    input wire logic regRvalid, // read valid
    input wire logic [70:0] nvImage, // image to keep
    input wire logic nvWrStrobe, // image save pulse
    output logic [70:0] nvRestoreImage // kept image
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        regRd = 1'b0;
        regWr = 1'b0;
        regAddr = 16'h0000;
        regWdata = 16'h0000;
        nvRestoreImage = '0;
    end
    always @(posedge clk) begin
        if (nvWrStrobe) begin
            nvRestoreImage <= nvImage;
        end
    end
    // released lines show the inverse, never the stale value
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        regAddr <= ~a;
        #1;
        d = regRvalid ? regRdata : 16'hdead;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~d;
    endtask
endmodule
`default_nettype wire

// *** verification/eelq_log_queue_tb.sv ***
// Purpose: self-checking bench of the event log queue
// Assumes: short hold and gap counts
// Notes: pop image kept by the master model
`include "eelq_cfg.svh"
`default_nettype none
module eelq_log_queue_tb
    import eelq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD = 50;
    localparam int GAP = 20;
    localparam logic [15:0] POP = `EELQ_ADDR_POP;
    localparam logic [15:0] HN = `EELQ_ADDR_HIST_NEWEST;
    logic clk, rst_b, regRd, regWr, regRvalid, evStrobe, tcpMode;
    logic rxByte, unlockTry, unlockFail, unlockRejected;
    logic measureHalted, nvWrStrobe;
    logic [15:0] regAddr, regWdata, regRdata;
    logic [70:0] nvRestoreImage, nvImage;
    logic [4:0] evSub;
    eelq_class_e evClass;
    int nMismatch = 0;
    int cmpCount = 0;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    eelq_log_queue #(.HOLD_CYC(HOLD), .GAP_CYC(GAP)) uut (
        .clk(clk), .rst_b(rst_b), .regRd(regRd), .regWr(regWr),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .regRvalid(regRvalid), .evStrobe(evStrobe), .evClass(evClass),
        .evSub(evSub), .tcpFramedSerialMode(tcpMode), .rxByte(rxByte),
        .unlockTry(unlockTry), .unlockFail(unlockFail),
        .unlockRejected(unlockRejected), .measureHalted(measureHalted),
        .nvRestoreImage(nvRestoreImage), .nvImage(nvImage),
        .nvWrStrobe(nvWrStrobe));
    eelq_master_model m (
        .clk(clk), .regRd(regRd), .regWr(regWr), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
        .nvImage(nvImage), .nvWrStrobe(nvWrStrobe),
        .nvRestoreImage(nvRestoreImage));
    task automatic completeRun();
        $display("compares %0d mismatches %0d", cmpCount, nMismatch);
        if (nMismatch == 0 && cmpCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmpCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        m.rd(a, d);
        chk(d, exp);
    endtask
    task automatic ev(input eelq_class_e c, input logic [4:0] s);
        @(posedge clk);
        evStrobe <= 1'b1;
        evClass <= c;
        evSub <= s;
        @(posedge clk);
        evStrobe <= 1'b0;
    endtask
    task automatic rx(input int n);
        repeat (n) begin
            @(posedge clk);
            rxByte <= 1'b1;
            @(posedge clk);
            rxByte <= 1'b0;
        end
    endtask
    task automatic powerCycle();
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic drain();
        logic [15:0] d;
        repeat (9) m.rd(POP, d);
    endtask
    task automatic t_empty();
        rdc(POP, 16'h0000);
        rdc(HN + 16'h0007, 16'h0000);
        rdc(16'h06b0, 16'h0000);
        $display("test empty done");
    endtask
    task automatic t_order();
        drain();
        for (int i = 0; i < 10; i++) ev(EV_ACC, 5'(i));
        for (int k = 0; k < 8; k++) begin
            rdc(HN + 16'(k), 16'h005d - 16'(k));
        end
        rdc(HN, 16'h005d);
        for (int k = 0; k < 8; k++) rdc(POP, 16'h0056 + 16'(k));
        rdc(POP, 16'h0000);
        $display("test order done");
    endtask
    task automatic t_power();
        for (int i = 0; i < 3; i++) ev(EV_ACC, 5'(i));
        rdc(POP, 16'h0054);
        // let the store take the image of that pop first
        @(posedge clk);
        powerCycle();
        rdc(HN, 16'h0000);
        rdc(POP, 16'h0055);
        rdc(POP, 16'h0056);
        rdc(POP, 16'h0000);
        $display("test power done");
    endtask
    task automatic t_clear();
        ev(EV_ACC, 5'h01);
        ev(EV_ACC, 5'h02);
        m.wr(HN + 16'h0002, 16'h0001);
        rdc(HN + 16'h0001, 16'h0055);
        m.wr(HN + 16'h0004, 16'h0000);
        for (int k = 0; k < 8; k++) rdc(HN + 16'(k), 16'h0000);
        rdc(POP, 16'h0055);
        m.wr(POP, 16'h0001);
        repeat (2) @(posedge clk);
        rdc(HN, 16'h00c5);
        rdc(POP, 16'h0056);
        $display("test clear done");
    endtask
    task automatic t_unlock();
        @(posedge clk);
        unlockFail <= 1'b1;
        @(posedge clk);
        unlockFail <= 1'b0;
        unlockTry <= 1'b1;
        @(posedge clk);
        unlockTry <= 1'b0;
        #1;
        chk({15'h0, unlockRejected}, 16'h0001);
        repeat (2) @(posedge clk);
        rdc(HN, 16'h00d1);
        repeat (HOLD + 5) @(posedge clk);
        unlockTry <= 1'b1;
        @(posedge clk);
        unlockTry <= 1'b0;
        #1;
        chk({15'h0, unlockRejected}, 16'h0000);
        $display("test unlock done");
    endtask
    task automatic t_short();
        m.wr(HN, 16'h0000);
        rx(4);
        repeat (GAP + 5) @(posedge clk);
        rdc(HN, 16'h0000);
        rx(3);
        repeat (GAP + 5) @(posedge clk);
        rdc(HN, 16'h00fc);
        @(posedge clk);
        tcpMode <= 1'b0;
        m.wr(HN, 16'h0000);
        ev(EV_TCPHDR, 5'h00);
        ev(EV_CRC, 5'h00);
        rdc(HN + 16'h0001, 16'h0000);
        $display("test short done");
    endtask
    task automatic t_codes();
        logic [23:0] tab [42] = '{
            24'h00003b, 24'h030044,
            24'h050046, 24'h05014a, 24'h06004b, 24'h06024d,
            24'h01003e, 24'h010442, 24'h040045,
            24'h07004e, 24'h070553, 24'h080054, 24'h08166a,
            24'h09006b, 24'h0a00c5, 24'h0b00c6, 24'h0c00c7,
            24'h0d00c8, 24'h0e00ca, 24'h0f00cb, 24'h1000cd,
            24'h1100ce, 24'h1200cf, 24'h1300d0, 24'h1400d3,
            24'h1401d4, 24'h1500d5, 24'h1600f1, 24'h1700f4,
            24'h1800f5, 24'h1900f2, 24'h1901f6, 24'h1a00f8,
            24'h1b00f9, 24'h1c00f7, 24'h1d00fa, 24'h1e00fb,
            24'h2000fe, 24'h2100ff, 24'h1f00fc, 24'h1f01fd,
            24'h020043};
        @(posedge clk);
        tcpMode <= 1'b1;
        foreach (tab[i]) begin
            ev(eelq_class_e'(tab[i][21:16]), tab[i][12:8]);
            rdc(HN, {8'h00, tab[i][7:0]});
        end
        chk({15'h0, measureHalted}, 16'h0001);
        $display("test codes done");
    endtask
    initial begin
        rst_b = 1'b0;
        evStrobe = 1'b0;
        evClass = EV_NVDATA;
        evSub = 5'h00;
        tcpMode = 1'b0;
        rxByte = 1'b0;
        unlockTry = 1'b0;
        unlockFail = 1'b0;
        powerCycle();
        t_empty();
        t_order();
        t_power();
        t_clear();
        t_unlock();
        t_short();
        t_codes();
        completeRun();
    end
    initial begin
        repeat (20000) @(posedge clk);
        nMismatch++;
        completeRun();
    end
endmodule
`default_nettype wire
